// file: acc_conversion_control.sv
/*
  Digital control of a 10-bit successive-approximation converter: control and
  result registers, conversion clock divider, start, abort, sleep handling and
  the hardware trigger.
  Assumes all inputs are synchronous to core_clk, that rc_half_tick pulses once
  per half period of the dedicated RC oscillator, and that the analog side
  compares the held input against the trial code on trial_code.
*/
// The plain strobed port and the register addresses were decided locally.
`include "acc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module acc_conversion_control
  import acc_pkg::*;
(
  input wire logic core_clk, // System clock, 100 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, the cycle after the strobe.
  input wire logic rc_half_tick, // Half period pulse of the RC oscillator.
  input wire logic sleep_req, // Processor is asleep.
  input wire logic compare_trigger, // Special event pulse of the compare unit.
  input wire logic comparator_high, // Held input is at or above trial code.
  output logic trigger_timer_clear, // Pulse that clears the trigger timer.
  output logic conv_irq_flag, // Conversion flag level.
  output logic wake_pulse, // Wakes the processor from sleep.
  output logic converter_power, // Powers the analog converter.
  output logic sample_hold, // High while the input is being held.
  output logic [9:0] trial_code, // Current successive approximation code.
  output logic [4:0] channel_select, // Selected input code.
  output logic channel_connected, // Selected code routes a real input.
  output logic neg_reference_select, // Low reference selection.
  output logic [1:0] pos_reference_select // High reference selection.
);

  // Register and sequencer state.
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic [7:0] res_high_ff;
  logic [7:0] res_low_ff;
  logic irq_flag_ff;
  logic irq_enable_ff;
  acc_state_t state_ff;
  logic [4:0] div_cnt_ff;
  logic [4:0] halves_ff;
  logic [3:0] bit_ff;
  logic [3:0] ndec_ff;
  logic [9:0] sar_ff;
  logic [2:0] delay_ff;
  logic sleep_off_ff;
  logic [7:0] rdata_ff;
  logic timer_clear_ff;
  logic wake_ff;
  logic power_ff;
  logic hold_ff;
  logic connected_ff;

  // Decoded strobes and derived conditions.
  logic wr_a;
  logic wr_b;
  logic wr_hi;
  logic wr_lo;
  logic wr_irq;
  logic use_rc;
  logic half_tick;
  logic busy;
  logic sw_start;
  logic sw_abort;
  logic sleep_abort;
  logic start_req;
  logic finish;
  logic abort;
  logic [4:0] div_half;
  logic [9:0] final_code;
  logic [9:0] part_code;
  logic [7:0] nxt_res_high;
  logic [7:0] nxt_res_low;
  logic [7:0] nxt_rdata;

  // Address decode of the register port.
  always_comb begin
    wr_a = 1'b0;
    wr_b = 1'b0;
    wr_hi = 1'b0;
    wr_lo = 1'b0;
    wr_irq = 1'b0;
    if (reg_wr && reg_addr == `ACC_OFF_CTRL_A) begin
      wr_a = 1'b1;
    end else if (reg_wr && reg_addr == `ACC_OFF_CTRL_B) begin
      wr_b = 1'b1;
    end else if (reg_wr && reg_addr == `ACC_OFF_RES_HIGH) begin
      wr_hi = 1'b1;
    end else if (reg_wr && reg_addr == `ACC_OFF_RES_LOW) begin
      wr_lo = 1'b1;
    end else if (reg_wr && reg_addr == `ACC_OFF_IRQ) begin
      wr_irq = 1'b1;
    end
  end

  // Start and abort requests from software, the trigger and sleep.
  always_comb begin
    use_rc = ctrl_b_ff[`ACC_B_CLK_LO +: 2] == 2'b11;
    busy = state_ff != ACC_IDLE;
    sw_start = wr_a && reg_wdata[`ACC_A_START] && !busy;
    sw_abort = wr_a && !reg_wdata[`ACC_A_START] && busy;
    sleep_abort = sleep_req && !use_rc && busy;
    start_req = (sw_start || (compare_trigger && !busy)) && ctrl_a_ff[`ACC_A_ENABLE];
    abort = sw_abort || sleep_abort;
    finish = state_ff == ACC_CONV && half_tick && halves_ff == `ACC_TOTAL_HALVES - 5'h01;
  end

  // Half period of the divided conversion clock less one, in system clock cycles.
  always_comb begin
    case (acc_clk_sel_t'(ctrl_b_ff[`ACC_B_CLK_HI:`ACC_B_CLK_LO]))
      ACC_DIV2: div_half = 5'h00;
      ACC_DIV4: div_half = 5'h01;
      ACC_DIV8: div_half = 5'h03;
      ACC_DIV16: div_half = 5'h07;
      ACC_DIV32: div_half = 5'h0F;
      ACC_DIV64: div_half = 5'h1F;
      default: div_half = 5'h00;
    endcase
    half_tick = use_rc ? rc_half_tick : (div_cnt_ff == div_half);
  end

  // Divider runs only during conversion so each period starts aligned.
  always_ff @(posedge core_clk) begin
    if (srst || state_ff != ACC_CONV || div_cnt_ff == div_half) begin
      div_cnt_ff <= 5'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 5'h01;
    end
  end

  // Sequencer: idle, one-instruction delay for RC clock, then conversion.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ACC_IDLE;
      delay_ff <= 3'h0;
    end else begin
      case (state_ff)
        ACC_IDLE: begin
          if (start_req && use_rc) begin
            state_ff <= ACC_DELAY;
            delay_ff <= 3'(`ACC_INSTR_CYCLES - 1);
          end else if (start_req) begin
            state_ff <= ACC_CONV;
          end
        end
        ACC_DELAY: begin
          if (abort || !ctrl_a_ff[`ACC_A_ENABLE]) begin
            state_ff <= ACC_IDLE;
          end else if (delay_ff == 3'h0) begin
            state_ff <= ACC_CONV;
          end else begin
            delay_ff <= delay_ff - 3'h1;
          end
        end
        ACC_CONV: begin
          if (abort || finish || !ctrl_a_ff[`ACC_A_ENABLE]) begin
            state_ff <= ACC_IDLE;
          end
        end
        default: state_ff <= ACC_IDLE;
      endcase
    end
  end

  // Successive approximation: hold 1.5 periods, then one bit per period.
  always_ff @(posedge core_clk) begin
    if (srst || state_ff != ACC_CONV) begin
      halves_ff <= 5'h00;
      bit_ff <= 4'h9;
      ndec_ff <= 4'h0;
      sar_ff <= 10'h000;
    end else if (half_tick) begin
      halves_ff <= halves_ff + 5'h01;
      if (halves_ff + 5'h01 == `ACC_HOLD_HALVES) begin
        sar_ff <= 10'h200;
      end else if (halves_ff + 5'h01 > `ACC_HOLD_HALVES && halves_ff[0]) begin
        sar_ff[bit_ff] <= comparator_high;
        ndec_ff <= ndec_ff + 4'h1;
        if (bit_ff != 4'h0) begin
          sar_ff[bit_ff - 4'h1] <= 1'b1;
          bit_ff <= bit_ff - 4'h1;
        end
      end
    end
  end

  // Final and partial codes; partial fills unresolved bits with the last one.
  always_comb begin
    final_code = sar_ff;
    if (halves_ff > `ACC_HOLD_HALVES && halves_ff[0]) begin
      final_code[bit_ff] = comparator_high;
    end
    part_code = 10'h000;
    for (int i = 0; i < 10; i++) begin
      if (ndec_ff == 4'h0) begin
        part_code[i] = 1'b0;
      end else if (i >= 10 - int'(ndec_ff)) begin
        part_code[i] = sar_ff[i];
      end else begin
        part_code[i] = sar_ff[10 - int'(ndec_ff)];
      end
    end
  end

  // Justification of the code about to be loaded.
  always_comb begin
    if (ctrl_b_ff[`ACC_B_FORMAT]) begin
      nxt_res_high = {6'h00, (finish ? final_code[9:8] : part_code[9:8])};
      nxt_res_low = finish ? final_code[7:0] : part_code[7:0];
    end else begin
      nxt_res_high = finish ? final_code[9:2] : part_code[9:2];
      nxt_res_low = {(finish ? final_code[1:0] : part_code[1:0]), 6'h00};
    end
  end

  // Result registers keep their contents through reset.
  always_ff @(posedge core_clk) begin
    if (state_ff == ACC_CONV && (finish || abort)) begin
      res_high_ff <= nxt_res_high;
      res_low_ff <= nxt_res_low;
    end else begin
      if (wr_hi) begin
        res_high_ff <= reg_wdata;
      end
      if (wr_lo) begin
        res_low_ff <= reg_wdata;
      end
    end
  end

  // First control register; the start bit follows the sequencer.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_a_ff <= `ACC_RST_CTRL_A;
    end else begin
      if (wr_a) begin
        ctrl_a_ff[`ACC_A_CHAN_HI:`ACC_A_ENABLE] <= reg_wdata[`ACC_A_CHAN_HI:`ACC_A_ENABLE];
      end
      if (start_req) begin
        ctrl_a_ff[`ACC_A_START] <= 1'b1;
      end else if (finish || abort || (wr_a && !reg_wdata[`ACC_A_START])) begin
        ctrl_a_ff[`ACC_A_START] <= 1'b0;
      end else if (wr_a && !ctrl_a_ff[`ACC_A_ENABLE]) begin
        ctrl_a_ff[`ACC_A_START] <= 1'b0;
      end else if (!busy && !start_req) begin
        ctrl_a_ff[`ACC_A_START] <= 1'b0;
      end
      ctrl_a_ff[7] <= 1'b0;
    end
  end

  // Second control register; bit 3 is not implemented.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_b_ff <= `ACC_RST_CTRL_B;
    end else if (wr_b) begin
      ctrl_b_ff <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
    end
  end

  // Conversion flag: set when a conversion completes, not on abort, cleared only by reset or a software write.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_flag_ff <= 1'b0;
      irq_enable_ff <= 1'b0;
    end else begin
      if (finish) begin
        irq_flag_ff <= 1'b1;
      end else if (wr_irq && !reg_wdata[`ACC_I_FLAG]) begin
        irq_flag_ff <= 1'b0;
      end
      if (wr_irq) begin
        irq_enable_ff <= reg_wdata[`ACC_I_ENABLE];
      end
    end
  end

  // Sleep power-down; released when the processor wakes.
  always_ff @(posedge core_clk) begin
    if (srst || !sleep_req) begin
      sleep_off_ff <= 1'b0;
    end else if (sleep_abort) begin
      sleep_off_ff <= 1'b1;
    end else if (!use_rc && !busy) begin
      sleep_off_ff <= 1'b1;
    end else if (finish && !irq_enable_ff) begin
      sleep_off_ff <= 1'b1;
    end
  end

  // Wake pulse and trigger timer clear pulse.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_ff <= 1'b0;
      timer_clear_ff <= 1'b0;
    end else begin
      wake_ff <= finish && sleep_req && irq_enable_ff;
      timer_clear_ff <= compare_trigger;
    end
  end

  // Analog-side controls, all registered.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_ff <= 1'b0;
      hold_ff <= 1'b0;
      connected_ff <= 1'b0;
    end else begin
      power_ff <= ctrl_a_ff[`ACC_A_ENABLE] && !sleep_off_ff;
      hold_ff <= state_ff == ACC_CONV;
      connected_ff <= ctrl_a_ff[`ACC_A_CHAN_HI:`ACC_A_CHAN_LO] <= `ACC_LAST_CHANNEL
        || ctrl_a_ff[`ACC_A_CHAN_HI:`ACC_A_CHAN_LO] >= 5'h1D;
    end
  end

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    nxt_rdata = 8'h00;
    if (!reg_rd) begin
      nxt_rdata = 8'h00;
    end else if (reg_addr == `ACC_OFF_CTRL_A) begin
      nxt_rdata = ctrl_a_ff;
    end else if (reg_addr == `ACC_OFF_CTRL_B) begin
      nxt_rdata = ctrl_b_ff;
    end else if (reg_addr == `ACC_OFF_RES_HIGH) begin
      nxt_rdata = res_high_ff;
    end else if (reg_addr == `ACC_OFF_RES_LOW) begin
      nxt_rdata = res_low_ff;
    end else if (reg_addr == `ACC_OFF_IRQ) begin
      nxt_rdata = {6'h00, irq_enable_ff, irq_flag_ff};
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs come from flip-flops.
  assign reg_rdata = rdata_ff;
  assign trigger_timer_clear = timer_clear_ff;
  assign conv_irq_flag = irq_flag_ff;
  assign wake_pulse = wake_ff;
  assign converter_power = power_ff;
  assign sample_hold = hold_ff;
  assign trial_code = sar_ff;
  assign channel_select = ctrl_a_ff[`ACC_A_CHAN_HI:`ACC_A_CHAN_LO];
  assign channel_connected = connected_ff;
  assign neg_reference_select = ctrl_b_ff[`ACC_B_NREF];
  assign pos_reference_select = ctrl_b_ff[`ACC_B_PREF_HI:`ACC_B_PREF_LO];

endmodule

`default_nettype wire

// file: acc_consts.svh
/*
  Constants of the converter control block: register offsets, field positions,
  reset values and timing counts.
  Assumes it is included by bare name wherever the block's constants are needed.
*/
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// Register offsets on the byte-wide register port.
`define ACC_OFF_CTRL_A 8'h00
`define ACC_OFF_CTRL_B 8'h01
`define ACC_OFF_RES_HIGH 8'h02
`define ACC_OFF_RES_LOW 8'h03
`define ACC_OFF_IRQ 8'h04

// Field positions in converter_control_a.
`define ACC_A_ENABLE 0
`define ACC_A_START 1
`define ACC_A_CHAN_LO 2
`define ACC_A_CHAN_HI 6

// Field positions in converter_control_b.
`define ACC_B_PREF_LO 0
`define ACC_B_PREF_HI 1
`define ACC_B_NREF 2
`define ACC_B_CLK_LO 4
`define ACC_B_CLK_HI 6
`define ACC_B_FORMAT 7

// Field positions in the flag register.
`define ACC_I_FLAG 0
`define ACC_I_ENABLE 1

// Reset values of the control registers.
`define ACC_RST_CTRL_A 8'h00
`define ACC_RST_CTRL_B 8'h00

// Conversion framing in half periods of the bit conversion period, and the last channel code.
`define ACC_HOLD_HALVES 5'h03
`define ACC_TOTAL_HALVES 5'h17
`define ACC_LAST_CHANNEL 5'h0B

// Extra instruction cycle before an RC-clocked conversion starts.
`define ACC_CLK_MHZ 100
`define ACC_INSTR_NS 40
`define ACC_INSTR_CYCLES ((`ACC_INSTR_NS * `ACC_CLK_MHZ + 999) / 1000)

`endif

// file: acc_pkg.sv
/*
  Types of the converter control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package acc_pkg;

  // Sequencer states, Gray coded along idle, delay, convert.
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_DELAY = 2'b01,
    ACC_CONV = 2'b11
  } acc_state_t;

  // Conversion clock selections.
  typedef enum logic [2:0] {
    ACC_DIV2 = 3'h0,
    ACC_DIV8 = 3'h1,
    ACC_DIV32 = 3'h2,
    ACC_RC_A = 3'h3,
    ACC_DIV4 = 3'h4,
    ACC_DIV16 = 3'h5,
    ACC_DIV64 = 3'h6,
    ACC_RC_B = 3'h7
  } acc_clk_sel_t;

endpackage

// file: acc_conv_checker.sv
/* Concurrent checks on the ports of the converter control block.
   Assumes it is bound to acc_conversion_control and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.svh"
module acc_conv_checker (
  input wire logic core_clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic [7:0] reg_addr, // Address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic sleep_req, // Sleep.
  input wire logic compare_trigger, // Trigger.
  input wire logic trigger_timer_clear, // Timer clear.
  input wire logic conv_irq_flag, // Flag.
  input wire logic wake_pulse, // Wake.
  input wire logic converter_power, // Power.
  input wire logic [9:0] trial_code, // Trial code.
  input wire logic [4:0] channel_select, // Channel.
  input wire logic channel_connected, // Connected.
  input wire logic neg_reference_select, // Low reference.
  input wire logic [1:0] pos_reference_select // High reference.
);
  logic en_ff;
  logic ie_ff;
  logic [7:0] cb_ff;
  logic [9:0] code_ff;
  logic [9:0] low_bit;
  logic clr_wr;
  // Software view of the enables and clock field, and the last trial code.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_ff <= 1'b0;
      ie_ff <= 1'b0;
      cb_ff <= 8'h00;
      code_ff <= 10'h000;
    end else begin
      code_ff <= trial_code;
      if (reg_wr && reg_addr == `ACC_OFF_CTRL_A)
        en_ff <= reg_wdata[0];
      if (reg_wr && reg_addr == `ACC_OFF_CTRL_B)
        cb_ff <= reg_wdata;
      if (reg_wr && reg_addr == `ACC_OFF_IRQ)
        ie_ff <= reg_wdata[1];
    end
  end
  // Lowest set bit of the previous code, and a software clear of the flag.
  assign low_bit = code_ff & (~code_ff + 10'h001);
  assign clr_wr = reg_wr && reg_addr == `ACC_OFF_IRQ && !reg_wdata[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Each check ties an output to the input or register state that causes it.
  AST_TRIG_CLEAR: assert property (compare_trigger |=> trigger_timer_clear)
    else $error("timer clear pulse missing");
  AST_POWER_ENABLE: assert property (!en_ff [*3] |-> !converter_power)
    else $error("converter powered while disabled");
  AST_SLEEP_OFF: assert property ((sleep_req && cb_ff[5:4] != 2'h3) [*3] |-> !converter_power)
    else $error("converter powered in sleep on divided clock");
  AST_WAKE: assert property (wake_pulse |-> ie_ff && $past(sleep_req))
    else $error("wake pulse without sleep and enable");
  AST_FLAG_HOLD: assert property (conv_irq_flag && !clr_wr |=> conv_irq_flag)
    else $error("flag dropped without software clear");
  AST_CTRL_A_TOP: assert property (reg_rd && reg_addr == `ACC_OFF_CTRL_A |=> !reg_rdata[7])
    else $error("control a bit 7 read as one");
  AST_CTRL_B_B3: assert property (reg_rd && reg_addr == `ACC_OFF_CTRL_B |=> !reg_rdata[3])
    else $error("control b bit 3 read as one");
  AST_CHAN: assert property (($stable(channel_select) && !$past(srst)) [*2] |->
    channel_connected == (channel_select <= 5'h0B || channel_select >= 5'h1D))
    else $error("channel connection wrong");
  AST_REFS: assert property (neg_reference_select == cb_ff[2] &&
    pos_reference_select == cb_ff[1:0])
    else $error("reference selection differs from register");
  AST_TRIAL: assert property (trial_code != code_ff && code_ff != 0 && trial_code != 0 |->
    ((trial_code ^ code_ff) & ~(low_bit | (low_bit >> 1))) == 10'h000)
    else $error("trial code step not one bit at a time");
  AST_RESET_STATE: assert property ($fell(srst) |-> !converter_power && !conv_irq_flag)
    else $error("state not cleared by reset");
  // Main scenarios reached.
  COV_WAKE: cover property (wake_pulse);
  COV_TRIG: cover property (trigger_timer_clear);
  COV_SLEEP_OFF: cover property (sleep_req && $fell(converter_power));
endmodule
bind acc_conversion_control acc_conv_checker acc_conv_checker_inst (.core_clk, .srst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_req, .compare_trigger,
  .trigger_timer_clear, .conv_irq_flag, .wake_pulse, .converter_power, .trial_code,
  .channel_select, .channel_connected, .neg_reference_select, .pos_reference_select);
`default_nettype wire

// file: acc_analog_model.sv
/* Behavioural analog side: held input compared against the trial code.
   Assumes the level input is the held analog value in converter codes. */
`timescale 1ns/1ns
`default_nettype none
module acc_analog_model (
  input wire logic core_clk, // Clock.
  input wire logic converter_power, // Power from the block.
  input wire logic [9:0] trial_code, // Trial code.
  input wire logic [9:0] level, // Held input level.
  input wire logic slow, // Answer one cycle late.
  output logic comparator_high // Decision.
);
  logic cmp_ff;
  logic junk_ff = 1'b0;
  // Late decision, and a toggling value so an unpowered comparator is never trusted.
  always_ff @(posedge core_clk) begin
    cmp_ff <= level >= trial_code;
    junk_ff <= !junk_ff;
  end
  // Decision only while powered; prompt or one cycle late.
  assign comparator_high = !converter_power ? junk_ff :
    (slow ? cmp_ff : level >= trial_code);
endmodule
`default_nettype wire

// file: testbench.sv
/* Self-checking testbench of the converter control block.
   Assumes the analog model as far side and the checker bound to the block. */
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.svh"
module testbench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rc_half_tick = 1'b0;
  logic sleep_req = 1'b0;
  logic compare_trigger = 1'b0;
  logic slow = 1'b0;
  logic rc_run = 1'b0;
  logic woke = 1'b0;
  logic [1:0] rc_cnt = 2'h0;
  logic [9:0] level = 10'h000;
  logic [7:0] reg_rdata;
  logic [9:0] trial_code;
  logic [4:0] channel_select;
  logic [1:0] pos_reference_select;
  logic comparator_high, trigger_timer_clear, conv_irq_flag, wake_pulse, converter_power;
  logic sample_hold, channel_connected, neg_reference_select;
  logic [2:0] sel_tab [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  logic [9:0] lvl_tab [6] = '{10'h2A5, 10'h15A, 10'h3FF, 10'h000, 10'h201, 10'h1FE};
  int mismatches = 0;
  int n_tests = 0;
  int n;
  // Core clock, and an RC half period tick every third cycle while enabled.
  always #5 core_clk = !core_clk;
  always @(posedge core_clk) begin
    rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    rc_half_tick <= rc_run && rc_cnt == 2'h0;
  end
  acc_conversion_control acc_conversion_control_inst (.core_clk, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rc_half_tick, .sleep_req, .compare_trigger, .comparator_high,
    .trigger_timer_clear, .conv_irq_flag, .wake_pulse, .converter_power, .sample_hold,
    .trial_code, .channel_select, .channel_connected, .neg_reference_select,
    .pos_reference_select);
  acc_analog_model acc_analog_model_inst (.core_clk, .converter_power, .trial_code, .level,
    .slow, .comparator_high);
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read, data compared in the following cycle.
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask
  // Bounded wait for the flag, noting any wake pulse on the way.
  task automatic wait_flag();
    n = 0;
    woke = 1'b0;
    #1;
    while (conv_irq_flag !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
      woke = woke | (wake_pulse === 1'b1);
    end
    @(posedge core_clk);
    #1;
    woke = woke | (wake_pulse === 1'b1);
  endtask
  // Full conversion with a cycle window and justified result checks.
  task automatic convert(input logic [7:0] cb, input logic [9:0] v, input int lo, input int hi);
    logic [15:0] res;
    res = cb[7] ? {6'h00, v} : {v, 6'h00};
    level <= v;
    wr(`ACC_OFF_CTRL_B, cb);
    wr(`ACC_OFF_CTRL_A, 8'h01);
    wr(`ACC_OFF_CTRL_A, 8'h03);
    wait_flag();
    check("conversion cycles", n >= lo && n <= hi, 1'b1);
    rdchk("result_high", `ACC_OFF_RES_HIGH, res[15:8]);
    rdchk("result_low", `ACC_OFF_RES_LOW, res[7:0]);
    rdchk("status done", `ACC_OFF_CTRL_A, 8'h01);
    check("hold idle", sample_hold, 1'b0);
    rdchk("flag set", `ACC_OFF_IRQ, 8'h01);
    wr(`ACC_OFF_IRQ, 8'h00);
    rdchk("flag cleared", `ACC_OFF_IRQ, 8'h00);
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rdchk("ctrl_a reset", `ACC_OFF_CTRL_A, `ACC_RST_CTRL_A);
    rdchk("ctrl_b reset", `ACC_OFF_CTRL_B, `ACC_RST_CTRL_B);
    rdchk("unmapped", 8'h07, 8'h00);
    wr(`ACC_OFF_CTRL_B, 8'hFF);
    rdchk("ctrl_b bits", `ACC_OFF_CTRL_B, 8'hF7);
    wr(`ACC_OFF_CTRL_A, 8'hFD);
    rdchk("ctrl_a bits", `ACC_OFF_CTRL_A, 8'h7D);
    wr(`ACC_OFF_RES_HIGH, 8'h5A);
    rdchk("result_high rw", `ACC_OFF_RES_HIGH, 8'h5A);
    for (int c = 0; c < 32; c++) begin
      wr(`ACC_OFF_CTRL_A, {1'b0, c[4:0], 2'b01});
      @(posedge core_clk);
      #1;
      check("channel", channel_select, c[4:0]);
      check("connected", channel_connected, c <= 11 || c >= 29);
    end
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      convert({i[0], sel_tab[i], 4'h0}, lvl_tab[i], 22 << i, (24 << i) + 4);
    end
    rc_run <= 1'b1;
    slow <= 1'b0; // A late answer cannot meet the first decision on the fastest clock.
    convert(8'hB0, 10'h133, 71, 76);
    level <= 10'h0F0;
    wr(`ACC_OFF_CTRL_B, 8'h80);
    compare_trigger <= 1'b1;
    @(posedge core_clk);
    compare_trigger <= 1'b0;
    #1;
    check("timer clear", trigger_timer_clear, 1'b1);
    rdchk("triggered busy", `ACC_OFF_CTRL_A, 8'h03);
    check("hold busy", sample_hold, 1'b1);
    wait_flag();
    rdchk("trig result", `ACC_OFF_RES_LOW, 8'hF0);
    wr(`ACC_OFF_CTRL_B, 8'hE0);
    for (int k = 0; k < 2; k++) begin
      level <= k ? 10'h1A5 : 10'h2A5;
      wr(`ACC_OFF_CTRL_A, 8'h03);
      rdchk("busy", `ACC_OFF_CTRL_A, 8'h03);
      n = 0;
      while (trial_code[8] !== 1'b1 && n < 2000) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      wr(`ACC_OFF_CTRL_A, 8'h01);
      rdchk("abort high", `ACC_OFF_RES_HIGH, k ? 8'h00 : 8'h03);
      rdchk("abort low", `ACC_OFF_RES_LOW, k ? 8'h00 : 8'hFF);
      rdchk("aborted idle", `ACC_OFF_CTRL_A, 8'h01);
    end
    wr(`ACC_OFF_CTRL_A, 8'h03);
    sleep_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check("power in sleep", converter_power, 1'b0);
    rdchk("enable kept", `ACC_OFF_CTRL_A, 8'h01);
    @(posedge core_clk);
    sleep_req <= 1'b0;
    wr(`ACC_OFF_CTRL_B, 8'hF0);
    for (int ie = 0; ie < 2; ie++) begin
      wr(`ACC_OFF_IRQ, {6'h00, ie[0], 1'b0});
      wr(`ACC_OFF_CTRL_A, 8'h03);
      sleep_req <= 1'b1;
      wait_flag();
      check("wake", woke, ie[0]);
      if (ie == 0)
        check("power after end", converter_power, 1'b0);
      rdchk("enable after sleep", `ACC_OFF_CTRL_A, 8'h01);
      @(posedge core_clk);
      sleep_req <= 1'b0;
    end
    wr(`ACC_OFF_IRQ, 8'h00);
    wr(`ACC_OFF_CTRL_A, 8'h03);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rdchk("ctrl_a after reset", `ACC_OFF_CTRL_A, 8'h00);
    check("power after reset", converter_power, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
